// ===== pkg/exr_consts.vh
`ifndef EXR_CONSTS_VH
`define EXR_CONSTS_VH

// ---------------
// Clock and timing
// ---------------
`define EXR_CLK_NS 40
`define EXR_FILT_NS 1000
`define EXR_FILT_CYC ((`EXR_FILT_NS + `EXR_CLK_NS - 1) / `EXR_CLK_NS)
`define EXR_FILT_W 5
`define EXR_T0_MS 100
`define EXR_T1_MS 5
`define EXR_T2_MS 1
`define EXR_T3_MS 125
`define EXR_MS_CYC(ms) (((ms) * 1000000) / `EXR_CLK_NS)
`define EXR_TMR_W 22

// ---------------
// Register indices, byte address is four times the index
// ---------------
`define EXR_IDX_LEVEL 7'h0F
`define EXR_IDX_EDGE 7'h1F
`define EXR_IDX_STAT 7'h20
`define EXR_IDX_MASK 7'h21
`define EXR_IDX_CTRL 7'h22
`define EXR_IDX_BANK 7'h23
`define EXR_IDX_PSW 7'h24
`define EXR_IDX_CORE 7'h25

// ---------------
// Source bits and vector codes
// ---------------
`define EXR_SRC_RMT 0
`define EXR_SRC_TMR 1
`define EXR_SRC_FSY 2
`define EXR_SRC_SER 3
`define EXR_CTRL_MPE 2

// ---------------
// Reset values
// ---------------
`define EXR_RST_EDGE 2'h0
`define EXR_RST_NIB 4'h0
`define EXR_RST_CTRL 3'h0

`endif

// ===== hdl/exr_top.v
// Function
// - Edge on either pin raises a request.
// - Select bit 0 rising, 1 falling, per pin.
// - Edge selects live in register 1FH.
// - Pin level latches readable at 0FH.
// - Select change can itself cause request.
// - Pulses under 1 us are rejected.
// - Level bits always follow the pins.
// - Flags set when disabled; software clears.
// - Enabled interrupt accepted in any program.
// - Only bank and status word auto-saved.
// - Bank and status word cleared after push.
// - Software-saved flags keep their values.
// - Enable before return takes effect after.
// - File 40H-7FH maps to current bank.
// - Timer requests with four period choices.
// - Serial end raises a request.
// - Fixed priority DMA, remote, timer, sync, serial.
// - Flags set regardless of enables.
//
// Decided for this implementation: the Avalon-MM slave port.
`include "exr_consts.vh"

module exr_top #(
  parameter T0_CYC = `EXR_MS_CYC(`EXR_T0_MS),
  parameter T1_CYC = `EXR_MS_CYC(`EXR_T1_MS),
  parameter T2_CYC = `EXR_MS_CYC(`EXR_T2_MS),
  parameter T3_CYC = `EXR_MS_CYC(`EXR_T3_MS)
) (
  input  wire        clk,
  input  wire        rst_b,
  input  wire [6:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  output reg  [31:0] avs_readdata,
  output wire        avs_waitrequest,
  input  wire        remote_pin,
  input  wire        frame_sync_pin,
  input  wire        dma_req,
  input  wire        serial_done,
  input  wire        instr_boundary,
  input  wire        enable_interrupts_op,
  input  wire        disable_interrupts_op,
  input  wire        return_from_interrupt,
  input  wire [6:0]  rf_addr,
  output wire        irq,
  output reg         int_accept,
  output reg  [1:0]  int_vector,
  output reg  [3:0]  bank_out,
  output reg  [3:0]  psw_out,
  output wire        mpe_out,
  output reg         rf_mem_hit,
  output reg  [9:0]  rf_mem_addr
);

  // ---------------
  // Constants
  // ---------------
  // Filter length in clocks, rounded up; cut to the counter width on purpose.
  localparam integer FILT_END = `EXR_FILT_CYC - 1;
  localparam [`EXR_FILT_W-1:0] FILT_LAST = FILT_END[`EXR_FILT_W-1:0];
  // Timer period ends; every period is at least two clocks and fits the counter.
  localparam [`EXR_TMR_W-1:0] P0 = T0_CYC[`EXR_TMR_W-1:0] - 1'b1;
  localparam [`EXR_TMR_W-1:0] P1 = T1_CYC[`EXR_TMR_W-1:0] - 1'b1;
  localparam [`EXR_TMR_W-1:0] P2 = T2_CYC[`EXR_TMR_W-1:0] - 1'b1;
  localparam [`EXR_TMR_W-1:0] P3 = T3_CYC[`EXR_TMR_W-1:0] - 1'b1;

  // ---------------
  // Declarations
  // ---------------
  reg  [1:0]  sync_a;      // First synchroniser stage.
  reg  [1:0]  sync_b;      // Second synchroniser stage.
  wire [1:0]  filt;        // Noise-free pin levels.
  reg  [1:0]  edge_sel;    // Edge select flip-flops.
  reg  [1:0]  eff_q;       // Previous polarity-adjusted level.
  wire [1:0]  eff;         // Polarity-adjusted level.
  wire [1:0]  pin_hit;     // Request pulse per pin.
  reg  [3:0]  req_flag;    // Sticky request flags.
  reg  [3:0]  perm;        // Permission (mask) flags.
  reg  [2:0]  ctrl;        // Timer select and pointer flag.
  reg  [`EXR_TMR_W-1:0] tmr_cnt; // Timer counter.
  reg  [`EXR_TMR_W-1:0] tmr_end; // Selected period end.
  wire        tmr_tick;    // Timer request pulse.
  reg         en_ff;       // Interrupt enable flip-flop.
  reg         ei_arm;      // Enable seen in this instruction.
  reg         ei_go;       // Enable due at next boundary.
  reg  [7:0]  stk0;        // Newest saved bank and status.
  reg  [7:0]  stk1;        // Older saved bank and status.
  reg  [1:0]  depth;       // Interrupt stack fill.
  reg         ack;         // Bus answer strobe.
  reg  [31:0] rd_mux;      // Read data before the latch.
  wire        bus_req;     // Any bus request.
  wire        wr_go;       // Write takes effect now.
  wire [3:0]  pend;        // Flags allowed by permission.
  wire        take;        // Accept at this boundary.
  reg  [1:0]  grant;       // Winning source index.
  reg  [3:0]  grant_vec;   // One-hot winning source.
  wire [3:0]  set_vec;     // Hardware set events.
  wire [3:0]  clr_vec;     // Clear requests.

  // ---------------
  // Pin synchroniser
  // ---------------
  // Pins are asynchronous, so they pass two flops first.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sync_a <= 2'h0;
      sync_b <= 2'h0;
    end else begin
      sync_a <= {frame_sync_pin, remote_pin};
      sync_b <= sync_a;
    end
  end

  // ---------------
  // Noise filter per pin
  // ---------------
  // A new level is taken only after it held for the
  // whole filter length; shorter pulses vanish.
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_filt
      reg [`EXR_FILT_W-1:0] cnt; // Stable-run counter.
      reg                   lvl; // Accepted level.
      always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          cnt <= {`EXR_FILT_W{1'b0}};
          lvl <= 1'b0;
        end else if (sync_b[g] == lvl) begin
          // Back to the old level, restart the run.
          cnt <= {`EXR_FILT_W{1'b0}};
        end else if (cnt == FILT_LAST) begin
          // Held long enough, take it.
          lvl <= sync_b[g];
          cnt <= {`EXR_FILT_W{1'b0}};
        end else begin
          cnt <= cnt + 1'b1;
        end
      end
      assign filt[g] = lvl;
    end
  endgenerate

  // ---------------
  // Edge detection
  // ---------------
  // The level is flipped by the select bit, so a select
  // change that flips it low to high is seen as an edge.
  assign eff = filt ^ edge_sel;
  // Previous sample of the adjusted level.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      eff_q <= 2'h0;
    end else begin
      eff_q <= eff;
    end
  end
  // Rising adjusted level gives one request pulse.
  assign pin_hit = eff & ~eff_q;

  // ---------------
  // Periodic timer
  // ---------------
  // Period end chosen by the two select bits.
  always @* begin
    case (ctrl[1:0])
      2'h0: tmr_end = P0;
      2'h1: tmr_end = P1;
      2'h2: tmr_end = P2;
      default: tmr_end = P3;
    endcase
  end
  // Free-running count; a select change to a shorter
  // period also wraps at once, avoiding a long wait.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tmr_cnt <= {`EXR_TMR_W{1'b0}};
    end else if (tmr_cnt >= tmr_end) begin
      tmr_cnt <= {`EXR_TMR_W{1'b0}};
    end else begin
      tmr_cnt <= tmr_cnt + 1'b1;
    end
  end
  // One pulse per period.
  assign tmr_tick = (tmr_cnt >= tmr_end);

  // ---------------
  // Bus handshake
  // ---------------
  // One wait state: the answer comes the cycle after
  // the request appears.
  assign bus_req = avs_read | avs_write;
  assign avs_waitrequest = bus_req & ~ack;
  assign wr_go = avs_write & ack;
  // Answer strobe toggles high for one cycle per request.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ack <= 1'b0;
    end else begin
      ack <= bus_req & ~ack;
    end
  end

  // ---------------
  // Priority and acceptance
  // ---------------
  assign pend = req_flag & perm;
  // Lowest index wins, matching the fixed order.
  always @* begin
    grant = 2'h3;
    grant_vec = 4'h8;
    if (pend[`EXR_SRC_RMT]) begin
      grant = 2'h0;
      grant_vec = 4'h1;
    end else if (pend[`EXR_SRC_TMR]) begin
      grant = 2'h1;
      grant_vec = 4'h2;
    end else if (pend[`EXR_SRC_FSY]) begin
      grant = 2'h2;
      grant_vec = 4'h4;
    end
  end
  // Taken at any instruction boundary; DMA goes first.
  assign take = instr_boundary & en_ff & (|pend) &
                ~dma_req;

  // ---------------
  // Request flags
  // ---------------
  assign set_vec = {serial_done, pin_hit[1], tmr_tick,
                    pin_hit[0]};
  assign clr_vec =
    ((wr_go && avs_address == `EXR_IDX_STAT) ?
      avs_writedata[3:0] : 4'h0) |
    (take ? grant_vec : 4'h0);
  // Set wins over clear so no event is lost. Enables
  // play no part in setting.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      req_flag <= `EXR_RST_NIB;
    end else begin
      req_flag <= (req_flag & ~clr_vec) |
                  set_vec;
    end
  end
  // Level interrupt while any allowed flag stands.
  assign irq = |pend;

  // ---------------
  // Enable flip-flop
  // ---------------
  // Enable waits one whole instruction, so an enable
  // just before the return lands after the return.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      en_ff <= 1'b0;
      ei_arm <= 1'b0;
      ei_go <= 1'b0;
    end else if (disable_interrupts_op) begin
      en_ff <= 1'b0;
      ei_arm <= 1'b0;
      ei_go <= 1'b0;
    end else if (take) begin
      // Acceptance enters the inhibit state.
      en_ff <= 1'b0;
      ei_arm <= enable_interrupts_op;
      ei_go <= 1'b0;
    end else begin
      if (instr_boundary) begin
        ei_arm <= enable_interrupts_op;
        ei_go <= ei_arm;
        if (ei_go) begin
          en_ff <= 1'b1;
        end
      end else if (enable_interrupts_op) begin
        ei_arm <= 1'b1;
      end
    end
  end

  // ---------------
  // Acceptance outputs
  // ---------------
  // Pulse and vector code for the core.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      int_accept <= 1'b0;
      int_vector <= 2'h0;
    end else begin
      int_accept <= take;
      if (take) begin
        int_vector <= grant;
      end
    end
  end

  // ---------------
  // Bank, status word and stack
  // ---------------
  // Two-level stack that drops the oldest on overflow.
  // Acceptance outranks a software write.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bank_out <= `EXR_RST_NIB;
      psw_out <= `EXR_RST_NIB;
      stk0 <= 8'h00;
      stk1 <= 8'h00;
      depth <= 2'h0;
    end else if (take) begin
      stk0 <= {bank_out, psw_out};
      stk1 <= stk0;
      bank_out <= `EXR_RST_NIB;
      psw_out <= `EXR_RST_NIB;
      if (depth != 2'h2) begin
        depth <= depth + 1'b1;
      end
    end else if (return_from_interrupt) begin
      {bank_out, psw_out} <= stk0;
      stk0 <= stk1;
      if (depth != 2'h0) begin
        depth <= depth - 1'b1;
      end
    end else if (wr_go) begin
      if (avs_address == `EXR_IDX_BANK) begin
        bank_out <= avs_writedata[3:0];
      end
      if (avs_address == `EXR_IDX_PSW) begin
        psw_out <= avs_writedata[3:0];
      end
    end
  end

  // ---------------
  // Software registers
  // ---------------
  // Edge selects, permissions and control. Control is
  // not touched by acceptance, so the pointer flag keeps
  // its value and software must set it up itself.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      edge_sel <= `EXR_RST_EDGE;
      perm <= `EXR_RST_NIB;
      ctrl <= `EXR_RST_CTRL;
    end else if (wr_go) begin
      case (avs_address)
        `EXR_IDX_EDGE: edge_sel <= avs_writedata[1:0];
        `EXR_IDX_MASK: perm <= avs_writedata[3:0];
        `EXR_IDX_CTRL: ctrl <= avs_writedata[2:0];
        default: ctrl <= ctrl;
      endcase
    end
  end
  assign mpe_out = ctrl[`EXR_CTRL_MPE];

  // ---------------
  // Read path
  // ---------------
  // Unmapped indices read as zero.
  always @* begin
    rd_mux = 32'h0000_0000;
    case (avs_address)
      `EXR_IDX_LEVEL: rd_mux[1:0] = filt;
      `EXR_IDX_EDGE: rd_mux[1:0] = edge_sel;
      `EXR_IDX_STAT: rd_mux[3:0] = req_flag;
      `EXR_IDX_MASK: rd_mux[3:0] = perm;
      `EXR_IDX_CTRL: rd_mux[2:0] = ctrl;
      `EXR_IDX_BANK: rd_mux[3:0] = bank_out;
      `EXR_IDX_PSW: rd_mux[3:0] = psw_out;
      `EXR_IDX_CORE: rd_mux[3:0] = {depth, ei_go, en_ff};
      default: rd_mux = 32'h0000_0000;
    endcase
  end
  // Read data is caught in the wait cycle and stands
  // in the answer cycle.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read & ~ack) begin
      avs_readdata <= rd_mux;
    end
  end

  // ---------------
  // Register file window
  // ---------------
  // Upper half of the file lands in the current bank,
  // whatever the general register pointer says.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rf_mem_hit <= 1'b0;
      rf_mem_addr <= 10'h000;
    end else begin
      rf_mem_hit <= rf_addr[6];
      rf_mem_addr <= {bank_out, rf_addr[5:0]};
    end
  end

endmodule // exr_top

// ===== verif/exr_assertions.sv
// ----------------
// Port checker
// ----------------
module exr_checker (
  input logic        clk,
  input logic        rst_b,
  input logic [6:0]  avs_address,
  input logic        avs_read,
  input logic        avs_write,
  input logic [31:0] avs_readdata,
  input logic        avs_waitrequest,
  input logic        dma_req,
  input logic        instr_boundary,
  input logic [6:0]  rf_addr,
  input logic        irq,
  input logic        int_accept,
  input logic [3:0]  bank_out,
  input logic [3:0]  psw_out,
  input logic        mpe_out,
  input logic        rf_mem_hit,
  input logic [9:0]  rf_mem_addr
);
  // One clock domain, so every check shares the clock and sleeps in reset.
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // A boundary free of DMA followed by the acceptance pulse.
  sequence accepted_s;
    instr_boundary && !dma_req ##1 int_accept;
  endsequence
  // A bus request in its wait cycle.
  sequence bus_wait_s;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  wait_one_a: assert property (bus_wait_s |=> !avs_waitrequest)
    else $error("bus wait lasted more than one cycle");
  accept_gate_a: assert property (int_accept |-> $past(instr_boundary && !dma_req && irq))
    else $error("acceptance without a pending unmasked request");
  dma_block_a: assert property (instr_boundary && dma_req |=> !int_accept)
    else $error("acceptance while DMA was pending");
  accept_clear_a: assert property (accepted_s |-> bank_out == 4'h0 && psw_out == 4'h0)
    else $error("bank or status word not zero after acceptance");
  mpe_keep_a: assert property (int_accept |-> $stable(mpe_out))
    else $error("pointer enable flag changed by acceptance");
  accept_once_a: assert property (int_accept |=> !int_accept [*3])
    else $error("acceptance repeated without a new enable");
  rf_map_a: assert property (rf_mem_hit |-> $past(rf_addr[6]) &&
    rf_mem_addr == {$past(bank_out), $past(rf_addr[5:0])}) else $error("register file window misrouted");
  level_width_a: assert property (avs_read && !avs_waitrequest && avs_address == 7'h0F |->
    avs_readdata[31:2] == 30'h0) else $error("level register upper bits not zero");
endmodule // exr_checker

bind exr_top exr_checker u_chk (.clk(clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .dma_req(dma_req),
  .instr_boundary(instr_boundary), .rf_addr(rf_addr), .irq(irq), .int_accept(int_accept),
  .bank_out(bank_out), .psw_out(psw_out), .mpe_out(mpe_out), .rf_mem_hit(rf_mem_hit), .rf_mem_addr(rf_mem_addr));

// ===== verif/exr_far_side.sv
// ----------------
// Remote receiver and frame sync source
// ----------------
module exr_far_side (
  output logic remote_pin,
  output logic frame_sync_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // Both sources idle low; they are push-pull, so no line ever floats.
  initial begin
    remote_pin = 1'b0;
    frame_sync_pin = 1'b0;
  end
  // Set one line; changes land off the clock grid, as real sources do.
  task automatic drive(input int p, input logic v);
    #7;
    if (p == 1) frame_sync_pin = v;
    else remote_pin = v;
  endtask
  // A spike shorter than the noise filter, as a receiver glitch would give.
  task automatic glitch(input int p, input int ns);
    drive(p, 1'b1);
    #(ns);
    drive(p, 1'b0);
  endtask
endmodule // exr_far_side

// ===== verif/external_interrupt_edge_request_bench.sv
`include "exr_consts.vh"
`define EXR_CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin err_count++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end

module external_interrupt_edge_request_bench;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------
  // Signals and notes
  // ----------------
  logic        clk, rst_b, avs_read, avs_write, dma_req, serial_done, instr_boundary;
  logic        enable_interrupts_op, disable_interrupts_op, return_from_interrupt;
  logic [6:0]  avs_address, rf_addr;
  logic [31:0] avs_writedata, fb, lb;
  wire  [31:0] avs_readdata;
  wire         avs_waitrequest, irq, int_accept, mpe_out, rf_mem_hit, remote_pin, frame_sync_pin;
  wire  [1:0]  int_vector;
  wire  [3:0]  bank_out, psw_out;
  wire  [9:0]  rf_mem_addr;
  logic [7:0]  lfsr_state = 8'h21;   // Random source, fixed start.
  logic [63:0] rd_note;              // Oldest read note: mask over expected.
  logic [1:0]  vec_note;             // Oldest vector note.
  logic [63:0] rd_notes[$];
  logic [1:0]  vec_notes[$];
  int          err_count = 0;
  int          checked = 0;
  int          per[4] = '{40, 20, 10, 50};  // Shortened timer periods.

  exr_top #(.T0_CYC(40), .T1_CYC(20), .T2_CYC(10), .T3_CYC(50)) dut (.clk(clk), .rst_b(rst_b),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .remote_pin(remote_pin),
    .frame_sync_pin(frame_sync_pin), .dma_req(dma_req), .serial_done(serial_done),
    .instr_boundary(instr_boundary), .enable_interrupts_op(enable_interrupts_op),
    .disable_interrupts_op(disable_interrupts_op), .return_from_interrupt(return_from_interrupt),
    .rf_addr(rf_addr), .irq(irq), .int_accept(int_accept), .int_vector(int_vector), .bank_out(bank_out),
    .psw_out(psw_out), .mpe_out(mpe_out), .rf_mem_hit(rf_mem_hit), .rf_mem_addr(rf_mem_addr));
  exr_far_side far (.remote_pin(remote_pin), .frame_sync_pin(frame_sync_pin));

  // ----------------
  // Clock, random core addresses, tasks
  // ----------------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  function automatic [7:0] lfsr_next(input [7:0] s);
    lfsr_next = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // The core's register file address wanders randomly to exercise the window.
  always @(posedge clk) begin
    lfsr_state <= lfsr_next(lfsr_state);
    rf_addr <= lfsr_state[6:0];
  end
  // One bus cycle; an idle cycle follows so no strobe is set twice in a step.
  task automatic bus(input logic wr, input [6:0] a, input [31:0] d);
    int n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    // The request stands until an edge samples waitrequest low.
    @(posedge clk);
    while (avs_waitrequest !== 1'b0 && n < 40) begin
      n++;
      @(posedge clk);
    end
    if (n >= 40) err_count++;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input [6:0] a, input [31:0] d);
    bus(1'b1, a, d);
  endtask
  // Timer bit is masked by callers other than the timer test, since it ticks on its own.
  task automatic rd(input [6:0] a, input [31:0] e, input [31:0] m);
    rd_notes.push_back({m, e});
    bus(1'b0, a, 32'h0);
  endtask
  // One instruction: optional enable or return, then its boundary pulse.
  task automatic step(input logic en, input logic ret);
    enable_interrupts_op <= en;
    return_from_interrupt <= ret;
    @(posedge clk);
    enable_interrupts_op <= 1'b0;
    return_from_interrupt <= 1'b0;
    instr_boundary <= 1'b1;
    @(posedge clk);
    instr_boundary <= 1'b0;
    @(posedge clk);
  endtask
  task automatic finish_test;
    if (err_count == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ----------------
  // Result monitor
  // ----------------
  // Outputs are settled at the falling edge; an unexpected result meets an unknown note.
  always @(negedge clk) begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
      rd_note = (rd_notes.size() > 0) ? rd_notes.pop_front() : 64'hx;
      `EXR_CHK("read data", rd_note[31:0], avs_readdata & rd_note[63:32])
    end
    if (int_accept === 1'b1) begin
      vec_note = (vec_notes.size() > 0) ? vec_notes.pop_front() : 2'hx;
      `EXR_CHK("vector", vec_note, int_vector)
    end
  end
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    finish_test();
  end

  // ----------------
  // Scenarios
  // ----------------
  initial begin
    {avs_read, avs_write, dma_req, serial_done, instr_boundary, rst_b} = 6'h00;
    {enable_interrupts_op, disable_interrupts_op, return_from_interrupt} = 3'h0;
    {avs_address, avs_writedata} = 39'h0;
    repeat (8) @(posedge clk);
    @(negedge clk) rst_b = 1'b1;  // Released mid-cycle, away from the sampling edge.
    @(posedge clk);
    rd(`EXR_IDX_EDGE, 32'h0, 32'hFFFFFFFF);
    rd(`EXR_IDX_MASK, 32'h0, 32'hFFFFFFFF);
    rd(7'h10, 32'h0, 32'hFFFFFFFF);
    wr(`EXR_IDX_LEVEL, 32'h3);
    rd(`EXR_IDX_LEVEL, 32'h0, 32'hFFFFFFFF);
    lb = {30'h0, lfsr_state[1:0]};
    wr(`EXR_IDX_EDGE, lb);
    rd(`EXR_IDX_EDGE, lb, 32'hFFFFFFFF);
    wr(`EXR_IDX_EDGE, 32'h0);
    for (int p = 0; p < 2; p++) begin
      fb = 32'h1 << (2 * p);
      lb = 32'h1 << p;
      wr(`EXR_IDX_STAT, 32'hF);
      far.drive(p, 1'b1);
      repeat (40) @(posedge clk);
      rd(`EXR_IDX_STAT, fb, fb);
      rd(`EXR_IDX_LEVEL, lb, 32'h3);
      wr(`EXR_IDX_STAT, fb);
      wr(`EXR_IDX_EDGE, lb);
      rd(`EXR_IDX_STAT, 32'h0, fb);
      wr(`EXR_IDX_EDGE, 32'h0);
      rd(`EXR_IDX_STAT, fb, fb);
      wr(`EXR_IDX_STAT, fb);
      wr(`EXR_IDX_EDGE, lb);
      far.drive(p, 1'b0);
      repeat (40) @(posedge clk);
      rd(`EXR_IDX_STAT, fb, fb);
      wr(`EXR_IDX_STAT, fb);
      wr(`EXR_IDX_EDGE, 32'h0);
      rd(`EXR_IDX_STAT, 32'h0, fb);
      wr(`EXR_IDX_EDGE, lb);
      rd(`EXR_IDX_STAT, fb, fb);
      wr(`EXR_IDX_STAT, fb);
      wr(`EXR_IDX_EDGE, 32'h0);
      far.glitch(p, 800);
      repeat (40) @(posedge clk);
      rd(`EXR_IDX_STAT, 32'h0, fb);
      rd(`EXR_IDX_LEVEL, 32'h0, 32'h3);
    end
    // A random first strobe, then its inverse, so both outcomes are seen.
    lb = {31'h0, lfsr_state[0]};
    for (int k = 0; k < 2; k++) begin
      serial_done <= lb[0] ^ k[0];
      @(posedge clk);
      serial_done <= 1'b0;
      rd(`EXR_IDX_STAT, {28'h0, lb[0] ^ k[0], 3'h0}, 32'h8);
      wr(`EXR_IDX_STAT, 32'h8);
    end
    for (int s = 0; s < 4; s++) begin
      wr(`EXR_IDX_CTRL, s);
      wr(`EXR_IDX_STAT, 32'h2);
      repeat (per[s] + 4) @(posedge clk);
      rd(`EXR_IDX_STAT, 32'h2, 32'h2);
    end
    // Both pins rise with interrupts off; priority and DMA hold-off follow.
    wr(`EXR_IDX_STAT, 32'hF);
    wr(`EXR_IDX_BANK, 32'hA);
    wr(`EXR_IDX_PSW, 32'h5);
    wr(`EXR_IDX_CTRL, 32'h4);
    wr(`EXR_IDX_MASK, 32'h5);
    far.drive(0, 1'b1);
    far.drive(1, 1'b1);
    repeat (40) @(posedge clk);
    rd(`EXR_IDX_STAT, 32'h5, 32'h5);
    `EXR_CHK("irq", 1'b1, irq)
    dma_req <= 1'b1;
    step(1'b1, 1'b0);
    step(1'b0, 1'b0);
    step(1'b0, 1'b0);
    dma_req <= 1'b0;
    vec_notes.push_back(2'h0);
    step(1'b0, 1'b0);
    rd(`EXR_IDX_BANK, 32'h0, 32'hF);
    rd(`EXR_IDX_PSW, 32'h0, 32'hF);
    rd(`EXR_IDX_CTRL, 32'h4, 32'h4);
    rd(`EXR_IDX_STAT, 32'h4, 32'h5);
    step(1'b1, 1'b0);
    rd(`EXR_IDX_CORE, 32'h2, 32'h3);
    vec_notes.push_back(2'h2);
    step(1'b0, 1'b1);
    rd(`EXR_IDX_BANK, 32'hA, 32'hF);
    rd(`EXR_IDX_PSW, 32'h5, 32'hF);
    rd(`EXR_IDX_CORE, 32'h1, 32'h3);
    step(1'b0, 1'b0);
    `EXR_CHK("irq", 1'b0, irq)
    // A disable cancels an enable that is still on its way.
    step(1'b1, 1'b0);
    disable_interrupts_op <= 1'b1;
    @(posedge clk);
    disable_interrupts_op <= 1'b0;
    rd(`EXR_IDX_CORE, 32'h0, 32'h3);
    repeat (4) @(posedge clk);
    `EXR_CHK("notes left", 32'h0, 32'(rd_notes.size() + vec_notes.size()))
    finish_test();
  end
endmodule // external_interrupt_edge_request_bench
